// [verilog/sarc_map.svh]
// Constants for the converter sequencing and serial readout block
`ifndef SARC_MAP_SVH
`define SARC_MAP_SVH
`define SARC_W           14
`define SARC_MSB         13
`define SARC_CLK_NS      40
`define SARC_CONV_MAX_NS 2250
`define SARC_CYC_MAX_NS  2500
`define SARC_BUSY_NS     70
`define SARC_LEAD_NS     7
`define SARC_EXT_HI_NS   20000
`define SARC_DIV         3
`define SARC_BIT_W       4
`define SARC_HI_W        10
`define SARC_CNT_W       8
`endif

// [verilog/sarc_pkg.sv]
// Types shared by the converter sequencing and readout block
`default_nettype none
`include "sarc_map.svh"
package sarc_pkg;
  typedef logic [`SARC_W-1:0] sarc_word_t;
  typedef struct packed {
    logic convert_start_n;
    logic power_down_n;
    logic rd_n;
    logic sclk;
    logic ext_clk_in;
    logic bipolar;
  } sarc_pins_t;
  typedef struct packed {
    logic dout;
    logic dout_oe;
    logic clk_out;
    logic clk_out_oe;
  } sarc_sout_t;
  typedef enum logic [1:0] {
    SARC_IDLE = 2'h0,
    SARC_CONV = 2'h1,
    SARC_DONE = 2'h3,
    SARC_FIN  = 2'h2
  } sarc_conv_t;
  typedef enum logic [1:0] {
    SARC_ACTIVE = 2'h0,
    SARC_NAP    = 2'h1,
    SARC_SLEEP  = 2'h3
  } sarc_pd_t;
endpackage
`default_nettype wire

// [verilog/sarc_fifo2.sv]
// Two-entry result buffer between conversion and serial shifter
`default_nettype none
module sarc_fifo2 #(
  parameter int unsigned W = 14
) (
  input  wire logic         clock,
  input  wire logic         resetn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic [W-1:0] mem_q [2];
  logic [W-1:0] mem_d [2];
  logic         wr_q, wr_d, rd_q, rd_d;
  logic [1:0]   cnt_q, cnt_d;
  logic         push, pop;

  generate
    if (W < 1) begin : g_chk
      $error("sarc_fifo2: width must be at least one");
    end
  endgenerate

  // Honest flags from the fill count
  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Next pointers, count and storage
  always_comb begin
    mem_d = mem_q;
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = in_data;
      wr_d        = ~wr_q;
    end
    if (pop) begin
      rd_d = ~rd_q;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 2'h1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 2'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      wr_q     <= 1'b0;
      rd_q     <= 1'b0;
      cnt_q    <= 2'h0;
    end else begin
      mem_q <= mem_d;
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  property p_fifo_bound;
    @(posedge clock) disable iff (!resetn) cnt_q != 2'h3;
  endproperty
  a_fifo_bound: assert property (p_fifo_bound)
    else $error("result buffer count out of range");
endmodule
`default_nettype wire

// [verilog/sarc_top.sv]
// Conversion sequencer, SAR logic and serial result readout
`default_nettype none
`include "sarc_map.svh"
module sarc_top #(
  parameter int unsigned DIV      = `SARC_DIV,
  parameter int unsigned EXT_IDLE = `SARC_EXT_HI_NS / `SARC_CLK_NS
) (
  input  wire logic                 clock,
  input  wire logic                 resetn,
  input  wire sarc_pkg::sarc_pins_t pins,
  input  wire logic                 comp_hi,
  output logic [`SARC_W-1:0]        dac_code,
  output logic                      sample_hold,
  output logic                      busy_n,
  output sarc_pkg::sarc_sout_t      sout,
  output sarc_pkg::sarc_pd_t        pd_mode
);
  import sarc_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  localparam int CONV_MAX_CYC = `SARC_CONV_MAX_NS / `SARC_CLK_NS;
  localparam int CYC_MAX_CYC  = `SARC_CYC_MAX_NS / `SARC_CLK_NS;
  localparam int BUSY_CYC     = (`SARC_BUSY_NS / `SARC_CLK_NS < 1) ? 1 :
                                `SARC_BUSY_NS / `SARC_CLK_NS;
  localparam int LEAD_CYC     = (`SARC_LEAD_NS + `SARC_CLK_NS - 1) /
                                `SARC_CLK_NS;
  localparam int CONV_CYC     = `SARC_W * DIV + 3;

  generate
    if (DIV < 1 || CONV_CYC > CONV_MAX_CYC || CONV_CYC > CYC_MAX_CYC ||
        LEAD_CYC > 1 || BUSY_CYC < 1 || DIV > 255 ||
        EXT_IDLE < 2 || EXT_IDLE > 1023) begin : g_chk
      $error("sarc_top: parameters cannot meet conversion timing");
    end
  endgenerate

  // Two-flop synchronisers for every pin; edges compare stage two with stage three
  sarc_pins_t s1_q, s2_q, s3_q;
  always_ff @(posedge clock) begin
    if (!resetn) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  logic cs_fall, pd_fall, sck_fall, ext_rise;
  assign cs_fall  = !s2_q.convert_start_n && s3_q.convert_start_n;
  assign pd_fall  = !s2_q.power_down_n && s3_q.power_down_n;
  assign sck_fall = !s2_q.sclk && s3_q.sclk;
  assign ext_rise = s2_q.ext_clk_in && !s3_q.ext_clk_in;

  // A line held high past its longest high time selects the internal clock
  logic [`SARC_HI_W-1:0] hi_q, hi_d;
  logic                  ext_mode;
  always_comb begin
    hi_d = hi_q;
    if (!s2_q.ext_clk_in) begin
      hi_d = '0;
    end else if (hi_q != `SARC_HI_W'(EXT_IDLE)) begin
      hi_d = hi_q + `SARC_HI_W'(1);
    end
  end
  always_ff @(posedge clock) begin
    if (!resetn) begin
      hi_q <= `SARC_HI_W'(EXT_IDLE);
    end else begin
      hi_q <= hi_d;
    end
  end
  assign ext_mode = (hi_q != `SARC_HI_W'(EXT_IDLE));

  // Power-down mode follows the read line at the power-down fall
  sarc_pd_t pd_q, pd_d;
  always_comb begin
    pd_d = pd_q;
    if (s2_q.power_down_n) begin
      pd_d = SARC_ACTIVE;
    end else if (pd_fall) begin
      pd_d = s2_q.rd_n ? SARC_SLEEP : SARC_NAP;
    end
  end
  always_ff @(posedge clock) begin
    if (!resetn) begin
      pd_q <= SARC_ACTIVE;
    end else begin
      pd_q <= pd_d;
    end
  end
  assign pd_mode = pd_q;

  // Conversion sequencer and successive approximation register
  sarc_conv_t           st_q, st_d;
  sarc_word_t           sar_q, sar_d, result;
  logic [`SARC_BIT_W-1:0] bit_q, bit_d;
  logic [7:0]           div_q, div_d;
  logic                 ext_conv_q, ext_conv_d;
  logic                 busy_q, busy_d, clk_out_q, clk_out_d;
  logic                 step, accept, fifo_ready, push;

  // A start is refused while busy, powered down or the buffer is full
  assign accept = cs_fall && st_q == SARC_IDLE && fifo_ready &&
                  pd_q == SARC_ACTIVE;
  assign step   = ext_conv_q ? ext_rise : (div_q == 8'(DIV - 1));
  assign push   = (st_q == SARC_DONE);
  // Offset binary to two's complement by flipping the sign bit
  assign result = s2_q.bipolar ? {~sar_q[`SARC_MSB], sar_q[`SARC_MSB-1:0]}
                               : sar_q;

  always_comb begin
    st_d       = st_q;
    sar_d      = sar_q;
    bit_d      = bit_q;
    div_d      = div_q;
    ext_conv_d = ext_conv_q;
    case (st_q)
      SARC_IDLE: begin
        if (accept) begin
          st_d       = SARC_CONV;
          sar_d      = '0;
          sar_d[`SARC_MSB] = 1'b1;
          bit_d      = `SARC_BIT_W'(`SARC_MSB);
          div_d      = 8'h00;
          ext_conv_d = ext_mode;
        end
      end
      SARC_CONV: begin
        div_d = step ? 8'h00 : div_q + 8'h01;
        if (step) begin
          sar_d[bit_q] = comp_hi;
          if (bit_q == `SARC_BIT_W'(0)) begin
            st_d = SARC_DONE;
          end else begin
            sar_d[bit_q - `SARC_BIT_W'(1)] = 1'b1;
            bit_d = bit_q - `SARC_BIT_W'(1);
          end
        end
      end
      SARC_DONE: begin
        st_d = SARC_FIN; // Word enters the buffer on this edge
      end
      SARC_FIN: begin
        st_d = SARC_IDLE;
      end
      default: begin
        st_d = SARC_IDLE;
      end
    endcase
    busy_d    = (st_d == SARC_IDLE);
    clk_out_d = (st_d == SARC_CONV) &&
                (ext_conv_d ? s2_q.ext_clk_in : div_d < 8'(DIV / 2 + 1));
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      st_q       <= SARC_IDLE;
      sar_q      <= '0;
      bit_q      <= '0;
      div_q      <= 8'h00;
      ext_conv_q <= 1'b0;
      busy_q     <= 1'b1;
      clk_out_q  <= 1'b0;
    end else begin
      st_q       <= st_d;
      sar_q      <= sar_d;
      bit_q      <= bit_d;
      div_q      <= div_d;
      ext_conv_q <= ext_conv_d;
      busy_q     <= busy_d;
      clk_out_q  <= clk_out_d;
    end
  end
  assign busy_n      = busy_q;
  assign dac_code    = sar_q;
  assign sample_hold = (st_q == SARC_IDLE);

  // Buffer lets a slow reader miss no word; a full buffer refuses starts
  sarc_word_t fifo_data;
  logic       fifo_valid, load;
  sarc_fifo2 #(.W(`SARC_W)) u_buf (
    .clock     (clock),
    .resetn    (resetn),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (result),
    .out_valid (fifo_valid),
    .out_ready (load),
    .out_data  (fifo_data)
  );

  // Serial shifter: MSB presented at load, next bit after each fall while read is low
  sarc_word_t             sh_q, sh_d;
  logic [`SARC_BIT_W-1:0] cnt_q, cnt_d;
  assign load = fifo_valid && (cnt_q == `SARC_BIT_W'(0));
  always_comb begin
    sh_d  = sh_q;
    cnt_d = cnt_q;
    if (load) begin
      sh_d  = fifo_data;
      cnt_d = `SARC_BIT_W'(`SARC_W);
    end else if (sck_fall && !s2_q.rd_n && cnt_q != `SARC_BIT_W'(0)) begin
      sh_d  = {sh_q[`SARC_MSB-1:0], 1'b0};
      cnt_d = cnt_q - `SARC_BIT_W'(1);
    end
  end
  always_ff @(posedge clock) begin
    if (!resetn) begin
      sh_q  <= '0;
      cnt_q <= '0;
    end else begin
      sh_q  <= sh_d;
      cnt_q <= cnt_d;
    end
  end

  // Pin drivers enabled only during a read
  assign sout.dout       = sh_q[`SARC_MSB];
  assign sout.dout_oe    = !s2_q.rd_n;
  assign sout.clk_out    = clk_out_q;
  assign sout.clk_out_oe = !s2_q.rd_n;

  // Helper: cycles spent converting
  logic [`SARC_CNT_W-1:0] conv_cnt_q;
  always_ff @(posedge clock) begin
    if (!resetn || st_q == SARC_IDLE) begin
      conv_cnt_q <= '0;
    end else if (conv_cnt_q != '1) begin
      conv_cnt_q <= conv_cnt_q + `SARC_CNT_W'(1);
    end
  end
  property p_start;
      accept |=> st_q == SARC_CONV && sar_q[`SARC_MSB];
  endproperty
  a_start: assert property (p_start)
    else $error("accepted start did not begin a conversion");
  property p_conv_time;
      (st_q != SARC_IDLE && !ext_conv_q) |->
        conv_cnt_q < `SARC_CNT_W'(CONV_MAX_CYC);
  endproperty
  a_conv_time: assert property (p_conv_time)
    else $error("internal conversion overran its time");
  property p_busy_fall;
      accept |=> !busy_n ##1 !busy_n;
  endproperty
  a_busy_fall: assert property (p_busy_fall)
    else $error("busy did not fall after start");
  property p_lead;
      $rose(busy_n) |-> $past(push, 2) && $past(st_q, 3) == SARC_CONV;
  endproperty
  a_lead: assert property (p_lead)
    else $error("busy rose without a stored result");
  property p_busy_hold;
      (st_q != SARC_IDLE) |-> !busy_n;
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("busy high during conversion");
  property p_float;
      s2_q.rd_n |-> !sout.dout_oe && !sout.clk_out_oe;
  endproperty
  a_float: assert property (p_float)
    else $error("outputs driven with read high");
  property p_nap;
      (pd_fall && !s2_q.rd_n) |=> pd_mode == SARC_NAP;
  endproperty
  a_nap: assert property (p_nap)
    else $error("nap not entered");
  property p_int_clk;
      accept && s2_q.ext_clk_in && s3_q.ext_clk_in &&
      hi_q == `SARC_HI_W'(EXT_IDLE) |=> !ext_conv_q;
  endproperty
  a_int_clk: assert property (p_int_clk)
    else $error("held-high external clock not ignored");
  property p_no_restart;
      (cs_fall && st_q == SARC_CONV && !step) |=>
        $stable(sar_q) && $stable(bit_q);
  endproperty
  a_no_restart: assert property (p_no_restart)
    else $error("conversion restarted");
  property p_shift;
      $changed(sout.dout) |-> $past(sck_fall) || $past(load);
  endproperty
  a_shift: assert property (p_shift)
    else $error("serial bit changed without a shift-clock fall");
  property p_msb;
      load |=> sout.dout == $past(fifo_data[`SARC_MSB]);
  endproperty
  a_msb: assert property (p_msb)
    else $error("word not presented MSB first");
  property p_twos;
      (push && s2_q.bipolar) |-> result[`SARC_MSB] != sar_q[`SARC_MSB];
  endproperty
  a_twos: assert property (p_twos)
    else $error("bipolar sign bit not flipped");
endmodule
`default_nettype wire

// [dv/sarc_host.sv]
// Host controller model: drives the pins and models the comparator
`default_nettype none
module sarc_host (
  input  wire logic                 clock,
  input  wire sarc_pkg::sarc_word_t dac_code,
  input  wire logic                 busy_n,
  input  wire sarc_pkg::sarc_sout_t sout,
  output var  sarc_pkg::sarc_pins_t pins,
  output logic                      comp_hi
);
  timeunit 1ns;
  timeprecision 1ps;
  import sarc_pkg::*;

  sarc_word_t vin     = 14'h0000;
  logic       ext_run = 1'b0;
  logic [2:0] ext_cnt = 3'h0;

  // Lines idle high, bipolar low; the shift clock stands still outside frames
  initial pins = 6'h3E;

  // Ideal comparator: keep the trial bit while the held input reaches it
  assign comp_hi = (vin >= dac_code);

  // Conversion clock 4 high 4 low, 3.125 MHz; held high selects internal
  always @(posedge clock) begin
    ext_cnt <= ext_cnt + 3'h1;
    pins.ext_clk_in <= !ext_run | !ext_cnt[2];
  end

  // Start pulse; released once busy shows, well inside 625 ns
  task automatic convert(input bit again, output int lat, output int len);
    lat = 0;
    len = 0;
    pins.convert_start_n <= 1'b0;
    do begin
      @(posedge clock);
      lat++;
    end while (busy_n !== 1'b0 && lat < 8);
    pins.convert_start_n <= 1'b1;
    do begin
      @(posedge clock);
      len++;
      if (again && len == 6) pins.convert_start_n <= 1'b0;
      if (again && len == 9) pins.convert_start_n <= 1'b1;
    end while (busy_n !== 1'b1 && len < 400);
  endtask

  // Read one word after busy rose; 320 ns shift clock, falling capture
  task automatic read_word(output sarc_word_t w, output logic ok);
    ok = 1'b1;
    pins.rd_n <= 1'b0;
    repeat (4) @(posedge clock);
    for (int i = 13; i >= 0; i--) begin
      w[i] = sout.dout;
      if (sout.dout_oe !== 1'b1) ok = 1'b0;
      pins.sclk <= 1'b0;
      repeat (2) @(posedge clock);
      // The old bit must still stand shortly after the fall
      if (sout.dout !== w[i]) ok = 1'b0;
      repeat (2) @(posedge clock);
      pins.sclk <= 1'b1;
      repeat (4) @(posedge clock);
    end
    pins.rd_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// [dv/sarc_adc_convert_serial_readout_tb.sv]
// Self-checking bench for the converter sequencing and readout block
`default_nettype none
module sarc_adc_convert_serial_readout_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sarc_pkg::*;

  localparam int unsigned DIV = 3;
  localparam int unsigned BUSY_LEN = 14 * DIV + 2;

  logic       clock  = 1'b0;
  logic       resetn = 1'b0;
  sarc_pins_t pins;
  logic       comp_hi;
  sarc_word_t dac_code;
  logic       sample_hold;
  logic       busy_n;
  sarc_sout_t sout;
  sarc_pd_t   pd_mode;
  int         fail_count = 0;
  int         n_compared = 0;
  int         cycles     = 0;
  int         clk_rises  = 0;
  logic       clk_seen_q = 1'b0;

  sarc_top #(.DIV(DIV), .EXT_IDLE(8)) dut (
    .clock       (clock),
    .resetn      (resetn),
    .pins        (pins),
    .comp_hi     (comp_hi),
    .dac_code    (dac_code),
    .sample_hold (sample_hold),
    .busy_n      (busy_n),
    .sout        (sout),
    .pd_mode     (pd_mode)
  );

  sarc_host host (
    .clock    (clock),
    .dac_code (dac_code),
    .busy_n   (busy_n),
    .sout     (sout),
    .pins     (pins),
    .comp_hi  (comp_hi)
  );

  // 25 MHz clock
  initial forever #20 clock = ~clock;

  // Cut a hang short; the whole run needs well under 10000 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      finish_test();
    end
  end

  // Pulses on the conversion clock output, compared for each internally clocked conversion in run_one
  always @(posedge clock) begin
    clk_seen_q <= sout.clk_out;
    if (sout.clk_out && !clk_seen_q) clk_rises++;
  end

  task automatic check(string what, logic [13:0] seen, logic [13:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One conversion and readout; blen 0 means external clock timing
  task automatic run_one(input sarc_word_t v, input logic bip,
                         input bit again, input int unsigned blen);
    int         lat;
    int         len;
    sarc_word_t w;
    logic       ok;
    int         rises;
    host.vin <= v;
    host.pins.bipolar <= bip;
    repeat (4) @(posedge clock);
    rises = clk_rises;
    host.convert(again, lat, len);
    check("start latency", 14'(lat <= 5), 14'h0001);
    if (blen != 0) begin
      check("busy length", 14'(len), 14'(blen));
      check("clock pulses", 14'(clk_rises - rises), 14'h000E);
    end else begin
      check("ext busy", 14'(len >= 100 && len <= 125), 14'h0001);
    end
    host.read_word(w, ok);
    check("result", w, bip ? v ^ 14'h2000 : v);
    check("bit hold", 14'(ok), 14'h0001);
    repeat (4) @(posedge clock);
    check("float", 14'(sout.dout_oe | sout.clk_out_oe), 14'h0000);
  endtask

  task automatic t_reset();
    repeat (2) @(posedge clock);
    check("reset busy", 14'(busy_n), 14'h0001);
    check("reset mode", 14'(pd_mode), 14'(SARC_ACTIVE));
    check("reset clk", 14'(sout.clk_out), 14'h0000);
    check("reset hold", 14'(sample_hold), 14'h0001);
    check("reset dac", dac_code, 14'h0000);
  endtask

  // Code table: ends of range, bipolar zero crossing
  task automatic t_codes();
    sarc_word_t v [6] = '{14'h2A5C, 14'h3FFF, 14'h0000,
                          14'h2000, 14'h1FFF, 14'h2001};
    logic [5:0] bips = 6'h38;
    for (int i = 0; i < 6; i++) begin
      run_one(v[i], bips[i], 1'b0, BUSY_LEN);
    end
  endtask

  // Three words stack up unread; a fourth start must be refused
  task automatic t_fill();
    int         lat;
    int         len;
    sarc_word_t w;
    logic       ok;
    sarc_word_t vals [3] = '{14'h0123, 14'h3210, 14'h1555};
    host.pins.bipolar <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      host.vin <= vals[i];
      repeat (2) @(posedge clock);
      host.convert(1'b0, lat, len);
      check("buffered busy", 14'(len), 14'(BUSY_LEN));
    end
    host.convert(1'b0, lat, len);
    check("full refusal", 14'(lat), 14'h0008);
    for (int i = 0; i < 3; i++) begin
      repeat (6) @(posedge clock);
      host.read_word(w, ok);
      check("buffer order", w, vals[i]);
    end
  endtask

  task automatic t_ext();
    host.ext_run <= 1'b1;
    repeat (16) @(posedge clock);
    run_one(14'h0F0F, 1'b0, 1'b0, 0);
    host.ext_run <= 1'b0;
    repeat (16) @(posedge clock);
    run_one(14'h3C3C, 1'b0, 1'b0, BUSY_LEN);
  endtask

  // Nap with read low, refusal while down, wake, then sleep with read high
  task automatic t_power();
    int lat;
    int len;
    host.pins.rd_n <= 1'b0;
    repeat (4) @(posedge clock);
    host.pins.power_down_n <= 1'b0;
    repeat (6) @(posedge clock);
    check("nap mode", 14'(pd_mode), 14'(SARC_NAP));
    host.convert(1'b0, lat, len);
    check("start while down", 14'(lat), 14'h0008);
    host.pins.power_down_n <= 1'b1;
    repeat (13) @(posedge clock); // wake-up wait
    host.pins.rd_n <= 1'b1;
    check("awake", 14'(pd_mode), 14'(SARC_ACTIVE));
    repeat (4) @(posedge clock);
    host.pins.power_down_n <= 1'b0;
    repeat (6) @(posedge clock);
    check("sleep mode", 14'(pd_mode), 14'(SARC_SLEEP));
    host.pins.power_down_n <= 1'b1;
    repeat (13) @(posedge clock);
    run_one(14'h0AAA, 1'b0, 1'b0, BUSY_LEN);
  endtask

  initial begin
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    t_reset();
    t_codes();
    run_one(14'h1ABC, 1'b0, 1'b1, BUSY_LEN);
    t_fill();
    t_ext();
    t_power();
    finish_test();
  end
endmodule
`default_nettype wire
